// ==== hdl/lcig_pkg.sv ====
// Constants shared by the logic cell input gating stage.
// Assumes an 8-bit register port with a 4-bit byte address.
package lcig_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 4;
  localparam int SEL_W   = 6;
  localparam int N_LINES = 4;
  localparam int N_GATES = 4;
  localparam int N_SRC   = 64;
  localparam int FN_W    = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_POL  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_SEL0 = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_GLS0 = 4'h6;

  // Field positions
  localparam int CTRL_ON_BIT   = 7;
  localparam int CTRL_STAT_BIT = 5;
  localparam int CTRL_FN_LSB   = 0;
  localparam int POL_OUT_BIT   = 7;
  localparam int POL_GATE_LSB  = 0;
  localparam int SEL_LSB       = 0;

  // Reset values
  localparam logic            CTRL_ON_RESET = 1'b0;
  localparam logic [FN_W-1:0] CTRL_FN_RESET = 3'h0;
  localparam logic            POL_OUT_RESET = 1'b0;
  localparam logic            STATE_RESET   = 1'b0;

  typedef enum logic [FN_W-1:0] {
    LCIG_FN_AND_OR  = 3'h0,
    LCIG_FN_OR_XOR  = 3'h1,
    LCIG_FN_AND4    = 3'h2,
    LCIG_FN_SR      = 3'h3,
    LCIG_FN_DFF_SR  = 3'h4,
    LCIG_FN_DFF2_R  = 3'h5,
    LCIG_FN_JK_R    = 3'h6,
    LCIG_FN_LATCH   = 3'h7
  } lcig_fn_t;

endpackage

// ==== hdl/lcig_core_if.sv ====
// Carrier between the cell top, its source selectors and its gates.
// Assumes all members are combinational, no clock of their own.
`timescale 1ns/10ps
`default_nettype none

interface lcig_core_if;
  logic [lcig_pkg::N_LINES-1:0][lcig_pkg::SEL_W-1:0]  data_sel;
  logic [lcig_pkg::N_LINES-1:0]                       data_line;
  logic [lcig_pkg::N_GATES-1:0][lcig_pkg::DATA_W-1:0] gate_en;
  logic [lcig_pkg::N_GATES-1:0]                       gate_invert;
  logic [lcig_pkg::N_GATES-1:0]                       gate_out;

  modport top  (output data_sel, output gate_en, output gate_invert,
                input data_line, input gate_out);
  modport mux  (input data_sel, output data_line);
  modport gate (input data_line, input gate_en, input gate_invert, output gate_out);
endinterface

`default_nettype wire

// ==== hdl/lcig_src_mux.sv ====
// Source selectors: each data line picks one of the source signals.
// Assumes the source bus is already synchronous to the cell clock.
`timescale 1ns/10ps
`default_nettype none

module lcig_src_mux #(
  parameter int N_SRC = lcig_pkg::N_SRC
) (
  input  wire logic [N_SRC-1:0] source_in,
  lcig_core_if.mux              core
);
  genvar i;
  generate
    for (i = 0; i < lcig_pkg::N_LINES; i++) begin : g_line
      assign core.data_line[i] = source_in[core.data_sel[i]]; // [RQ4] [RQ5]
    end
  endgenerate
endmodule

`default_nettype wire

// ==== hdl/lcig_gates.sv ====
// Four data gates: enabled true and negated data forms are ORed, then
// the gate polarity is applied.
// Assumes enable byte layout: bit 2k+1 true, bit 2k negated of line k.
`timescale 1ns/10ps
`default_nettype none

module lcig_gates (
  lcig_core_if.gate core
);
  genvar g;
  generate
    for (g = 0; g < lcig_pkg::N_GATES; g++) begin : g_gate
      logic [lcig_pkg::N_LINES-1:0] true_hit;
      logic [lcig_pkg::N_LINES-1:0] neg_hit;
      genvar k;
      for (k = 0; k < lcig_pkg::N_LINES; k++) begin : g_term
        assign true_hit[k] = core.gate_en[g][2*k+1] & core.data_line[k];   // [RQ6] [RQ8]
        assign neg_hit[k]  = core.gate_en[g][2*k] & ~core.data_line[k];    // [RQ7] [RQ8]
      end
      assign core.gate_out[g] = (|true_hit | |neg_hit) ^ core.gate_invert[g]; // [RQ13] [RQ2]
    end
  endgenerate
endmodule

`default_nettype wire

// ==== hdl/lcig_top.sv ====
// Configurable logic cell: register file, input selection and gating,
// function select and output polarity.
// Assumes a single-cycle register port; read data appear the cycle after.
//
// How it works
// [RQ1] The cell output polarity bit inverts the function result on its way to the output.
// [RQ2] Gate polarity bits 0 to 3 invert gates 0 to 3 before the function sees them.
// [RQ3] Unused bits of the polarity and select registers read as zero.
// [RQ4] Bits 5 to 0 of the first select register choose the source of data line 1.
// [RQ5] Data lines 2 to 4 have their own select fields with the same source coding.
// [RQ6] Gate enable bits 7, 5, 3, 1 pass data lines 4, 3, 2, 1 true into the gate.
// [RQ7] Gate enable bits 6, 4, 2, 0 pass data lines 4, 3, 2, 1 negated into the gate.
// [RQ8] A cleared enable bit keeps that data form out of the gate entirely.
// [RQ9] Output polarity resets to zero; gate polarity, select and enable settings are not reset and keep their values.
// [RQ10] The readable status bit shows the cell output after output polarity.
// [RQ11] A 3-bit function select picks one of eight logic functions, codes 000 to 111.
// [RQ12] Reset clears the cell control register and the output polarity bit, leaving selection and gating alone.
// [RQ13] A gate is the OR of all its enabled data forms, zero when none is enabled.
// [RQ14] Software sets up selects, gates and polarity with the cell off, then turns it on.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module lcig_top #(
  parameter int N_SRC = lcig_pkg::N_SRC
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic [lcig_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [lcig_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [lcig_pkg::DATA_W-1:0] rdata_out,
  input  wire logic [N_SRC-1:0]            source_in,
  output logic      [lcig_pkg::N_GATES-1:0] gate_out,
  output logic                             cell_result_out
);

  localparam int NL = lcig_pkg::N_LINES;
  localparam int NG = lcig_pkg::N_GATES;
  localparam int DW = lcig_pkg::DATA_W;
  localparam int SW = lcig_pkg::SEL_W;
  localparam int FW = lcig_pkg::FN_W;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  lcig_core_if core ();

  lcig_src_mux #(
    .N_SRC (N_SRC)
  ) u_src_mux (
    .source_in (source_in),
    .core      (core)
  );

  lcig_gates u_gates (
    .core (core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register: cleared by every reset

  logic                 cell_on;
  logic                 next_cell_on;
  lcig_pkg::lcig_fn_t   cell_function_sel;
  lcig_pkg::lcig_fn_t   next_cell_function_sel;
  logic                 cell_output_invert;
  logic                 next_cell_output_invert;

  always_comb begin
    next_cell_on            = cell_on;
    next_cell_function_sel  = cell_function_sel;
    next_cell_output_invert = cell_output_invert;
    if (wr_in && addr_in == lcig_pkg::OFF_CTRL) begin
      next_cell_on           = wdata_in[lcig_pkg::CTRL_ON_BIT];
      next_cell_function_sel = lcig_pkg::lcig_fn_t'(wdata_in[lcig_pkg::CTRL_FN_LSB +: FW]);
    end
    if (wr_in && addr_in == lcig_pkg::OFF_POL) begin
      next_cell_output_invert = wdata_in[lcig_pkg::POL_OUT_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cell_on            <= lcig_pkg::CTRL_ON_RESET;                     // [RQ12]
      cell_function_sel  <= lcig_pkg::lcig_fn_t'(lcig_pkg::CTRL_FN_RESET); // [RQ12]
      cell_output_invert <= lcig_pkg::POL_OUT_RESET;                     // [RQ9]
    end else begin
      cell_on            <= next_cell_on;
      cell_function_sel  <= next_cell_function_sel;
      cell_output_invert <= next_cell_output_invert;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selection and gating settings: no reset, they survive every reset

  logic [NG-1:0]         gate_invert;
  logic [NG-1:0]         next_gate_invert;
  logic [NL-1:0][SW-1:0] data_source_sel;
  logic [NL-1:0][SW-1:0] next_data_source_sel;
  logic [NG-1:0][DW-1:0] gate_input_en;
  logic [NG-1:0][DW-1:0] next_gate_input_en;

  always_comb begin
    next_gate_invert     = gate_invert;
    next_data_source_sel = data_source_sel;
    next_gate_input_en   = gate_input_en;
    if (wr_in && addr_in == lcig_pkg::OFF_POL) begin
      next_gate_invert = wdata_in[lcig_pkg::POL_GATE_LSB +: NG];
    end
    for (int i = 0; i < NL; i++) begin
      if (wr_in && addr_in == lcig_pkg::OFF_SEL0 + lcig_pkg::ADDR_W'(i)) begin
        next_data_source_sel[i] = wdata_in[lcig_pkg::SEL_LSB +: SW];
      end
    end
    for (int i = 0; i < NG; i++) begin
      if (wr_in && addr_in == lcig_pkg::OFF_GLS0 + lcig_pkg::ADDR_W'(i)) begin
        next_gate_input_en[i] = wdata_in;
      end
    end
  end

  // Unknown until first written, as on a cold start
  always_ff @(posedge clk_in) begin
    gate_invert     <= next_gate_invert;      // [RQ9]
    data_source_sel <= next_data_source_sel;  // [RQ9]
    gate_input_en   <= next_gate_input_en;    // [RQ9]
  end

  assign core.data_sel    = data_source_sel;   // [RQ4] [RQ5]
  assign core.gate_en     = gate_input_en;     // [RQ6] [RQ7]
  assign core.gate_invert = gate_invert;       // [RQ2]

  ////////////////////////////////////////////////////////////////////////////
  // Logic function
  // Gate 0 acts as clock or enable in the stored modes other than SR, where it sets; its rising edge is
  // found against its previous sample, so all state stays on clk_in.

  logic [NG-1:0] g;
  logic          g0_prev;
  logic          next_g0_prev;
  logic          cell_state;
  logic          next_cell_state;
  logic          fn_value;
  logic          g0_rise;
  logic          set_in;
  logic          clr_in;
  logic          d_in;

  assign g       = core.gate_out;
  assign g0_rise = g[0] & ~g0_prev;

  always_comb begin
    next_g0_prev    = g[0];
    next_cell_state = cell_state;
    fn_value        = cell_state;
    set_in          = g[3];
    clr_in          = g[2];
    d_in            = g[1];
    case (cell_function_sel)                                            // [RQ11]
      lcig_pkg::LCIG_FN_AND_OR: begin
        fn_value = (g[0] & g[1]) | (g[2] & g[3]);
      end
      lcig_pkg::LCIG_FN_OR_XOR: begin
        fn_value = (g[0] | g[1]) ^ (g[2] | g[3]);
      end
      lcig_pkg::LCIG_FN_AND4: begin
        fn_value = &g;
      end
      lcig_pkg::LCIG_FN_SR: begin
        set_in = g[0] | g[1];
        clr_in = g[2] | g[3];
        if (set_in) begin
          next_cell_state = 1'b1;
        end else if (clr_in) begin
          next_cell_state = 1'b0;
        end
      end
      lcig_pkg::LCIG_FN_DFF_SR: begin
        if (clr_in) begin
          next_cell_state = 1'b0;
        end else if (set_in) begin
          next_cell_state = 1'b1;
        end else if (g0_rise) begin
          next_cell_state = d_in;
        end
      end
      lcig_pkg::LCIG_FN_DFF2_R: begin
        d_in = g[1] & g[3];
        if (clr_in) begin
          next_cell_state = 1'b0;
        end else if (g0_rise) begin
          next_cell_state = d_in;
        end
      end
      lcig_pkg::LCIG_FN_JK_R: begin
        if (clr_in) begin
          next_cell_state = 1'b0;
        end else if (g0_rise) begin
          case ({g[1], g[3]})
            2'h2:    next_cell_state = 1'b1;
            2'h1:    next_cell_state = 1'b0;
            2'h3:    next_cell_state = ~cell_state;
            default: next_cell_state = cell_state;
          endcase
        end
      end
      lcig_pkg::LCIG_FN_LATCH: begin
        if (clr_in) begin
          next_cell_state = 1'b0;
        end else if (set_in) begin
          next_cell_state = 1'b1;
        end else if (g[0]) begin
          next_cell_state = d_in;
        end
        fn_value = clr_in ? 1'b0 : (set_in ? 1'b1 : (g[0] ? d_in : cell_state));
      end
      default: begin
        fn_value = 1'b0;
      end
    endcase
    if (!cell_on) begin
      next_cell_state = lcig_pkg::STATE_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: a disabled cell drives zero on cell_result_out; gate_out still follows the gates

  logic cell_result;
  logic next_cell_result;
  logic [NG-1:0] gate_reg;
  logic [NG-1:0] next_gate_reg;

  always_comb begin
    next_cell_result = cell_on & (fn_value ^ cell_output_invert);       // [RQ1]
    next_gate_reg    = g;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      g0_prev     <= lcig_pkg::STATE_RESET;
      cell_state  <= lcig_pkg::STATE_RESET;
      cell_result <= lcig_pkg::STATE_RESET;
      gate_reg    <= '0;
    end else begin
      g0_prev     <= next_g0_prev;
      cell_state  <= next_cell_state;
      cell_result <= next_cell_result;
      gate_reg    <= next_gate_reg;
    end
  end

  assign cell_result_out = cell_result;
  assign gate_out        = gate_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data in the cycle after the read strobe

  logic [DW-1:0] rdata;
  logic [DW-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (rd_in) begin
      if (addr_in == lcig_pkg::OFF_CTRL) begin
        next_rdata[lcig_pkg::CTRL_ON_BIT]        = cell_on;
        next_rdata[lcig_pkg::CTRL_STAT_BIT]      = cell_result;          // [RQ10]
        next_rdata[lcig_pkg::CTRL_FN_LSB +: FW]  = cell_function_sel;
      end
      if (addr_in == lcig_pkg::OFF_POL) begin
        next_rdata[lcig_pkg::POL_OUT_BIT]        = cell_output_invert;   // [RQ3]
        next_rdata[lcig_pkg::POL_GATE_LSB +: NG] = gate_invert;
      end
      for (int i = 0; i < NL; i++) begin
        if (addr_in == lcig_pkg::OFF_SEL0 + lcig_pkg::ADDR_W'(i)) begin
          next_rdata[lcig_pkg::SEL_LSB +: SW] = data_source_sel[i];      // [RQ3]
        end
      end
      for (int i = 0; i < NG; i++) begin
        if (addr_in == lcig_pkg::OFF_GLS0 + lcig_pkg::ADDR_W'(i)) begin
          next_rdata = gate_input_en[i];
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;

endmodule

`default_nettype wire

// ==== testbench/lcig_top_sva.sv ====
// Checker for the logic cell stage: register readback, gating and result.
// Assumes it is bound to lcig_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module lcig_top_sva #(
  parameter int N_SRC = 64
) (
  input wire logic                          clk_in,
  input wire logic                          rst_in,
  input wire logic [lcig_pkg::ADDR_W-1:0]  addr_in,
  input wire logic [lcig_pkg::DATA_W-1:0]  wdata_in,
  input wire logic                          wr_in,
  input wire logic                          rd_in,
  input wire logic [lcig_pkg::DATA_W-1:0]  rdata_out,
  input wire logic [N_SRC-1:0]              source_in,
  input wire logic [lcig_pkg::N_GATES-1:0] gate_out,
  input wire logic                          cell_result_out
);
  logic [7:0] sh [10];
  logic [9:0] wrt;
  logic [7:0] rd_exp;
  logic [3:0] dl;
  logic [3:0] eg;
  logic       fn;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ////////////////////////////////////////////////////////////////////////
  // Shadow of the register file, implemented bits only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh[0]    <= 8'h00;
      sh[1][7] <= 1'b0;
    end else if (wr_in && addr_in < 4'ha) begin
      sh[addr_in]  <= wdata_in & (addr_in == 4'h0 ? 8'h87 : addr_in == 4'h1 ? 8'h8f :
                                  addr_in < 4'h6 ? 8'h3f : 8'hff);
      wrt[addr_in] <= 1'b1;
    end
  end

  always_comb begin
    rd_exp = (addr_in < 4'ha) ? sh[addr_in] : 8'h00;
    for (int k = 0; k < 4; k++) dl[k] = source_in[sh[2+k][5:0]];
    for (int g = 0; g < 4; g++) begin
      eg[g] = |(sh[6+g] & {dl[3], ~dl[3], dl[2], ~dl[2], dl[1], ~dl[1], dl[0], ~dl[0]})
              ^ sh[1][g];
    end
    case (sh[0][2:0])
      3'h0:    fn = (eg[0] & eg[1]) | (eg[2] & eg[3]);
      3'h1:    fn = (eg[0] | eg[1]) ^ (eg[2] | eg[3]);
      default: fn = &eg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_rd(a);
    rd_in && addr_in == a;
  endsequence
  sequence s_rd_sel;
    rd_in && addr_in >= lcig_pkg::OFF_SEL0 && addr_in < lcig_pkg::OFF_GLS0;
  endsequence

  AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  AST_READBACK: assert property (rd_in && addr_in != 4'h0 |=> rdata_out == $past(rd_exp))
    else $error("register readback differs from last write");
  AST_POL_RSV: assert property (s_rd(lcig_pkg::OFF_POL) |=> rdata_out[6:4] == 3'h0)
    else $error("unused polarity bits not zero");
  AST_SEL_RSV: assert property (s_rd_sel |=> rdata_out[7:6] == 2'h0)
    else $error("unused select bits not zero");
  AST_STATUS: assert property (s_rd(lcig_pkg::OFF_CTRL) |=>
    rdata_out[5] == $past(cell_result_out) && (rdata_out & 8'hdf) == $past(sh[0]))
    else $error("control read or status bit wrong");
  AST_GATE: assert property (!rst_in && &wrt[9:1] |=> gate_out == $past(eg))
    else $error("gate output differs from selected and enabled data");
  AST_RESULT: assert property (sh[0][7] && sh[0][2:0] < 3'h3 && &wrt[9:1] |=>
    cell_result_out == $past(fn ^ sh[1][7]))
    else $error("cell result differs from function and output polarity");
  AST_OFF: assert property (!sh[0][7] |=> !cell_result_out)
    else $error("disabled cell output not zero");
  AST_RST: assert property ($past(rst_in) |-> gate_out == 4'h0 && !cell_result_out)
    else $error("outputs not cleared by reset");
endmodule

bind lcig_top lcig_top_sva #(.N_SRC(N_SRC)) u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .source_in(source_in),
  .gate_out(gate_out), .cell_result_out(cell_result_out));

`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the logic cell stage through its register port.
// Assumes lcig_top with 64 sources and the byte map of lcig_pkg.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        clk_in;
  logic        rst_in;
  logic        wr_in;
  logic        rd_in;
  logic [3:0]  addr_in;
  logic [7:0]  wdata_in;
  logic [7:0]  rdata_out;
  logic [7:0]  rd_v;
  logic [63:0] source_in;
  logic [3:0]  gate_out;
  logic [3:0]  g;
  logic        cell_result_out;
  logic        e;
  logic [5:0]  sv [4] = '{6'h05, 6'h11, 6'h28, 6'h3f};
  logic [7:0]  sl_pol [4] = '{8'h01, 8'h00, 8'h04, 8'h80};
  logic [3:0]  sl_exp = 4'b1011;
  int          n_fail;
  int          n_compared;

  lcig_top dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .source_in(source_in),
    .gate_out(gate_out), .cell_result_out(cell_result_out));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    source_in = 64'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    // Setup with the cell off, unused bits written as ones
    wr(lcig_pkg::OFF_CTRL, 8'h00);
    wr(lcig_pkg::OFF_POL, 8'hff);
    for (int k = 0; k < 4; k++) wr(4'(lcig_pkg::OFF_SEL0 + k), {2'b11, sv[k]});
    for (int k = 0; k < 4; k++) wr(4'(lcig_pkg::OFF_GLS0 + k), 8'(8'h5a + k));
    wr(4'ha, 8'hff);
    rd(lcig_pkg::OFF_POL, rd_v);
    chk(rd_v, 8'h8f);
    for (int k = 0; k < 4; k++) begin
      rd(4'(lcig_pkg::OFF_SEL0 + k), rd_v);
      chk(rd_v, {2'b00, sv[k]});
      rd(4'(lcig_pkg::OFF_GLS0 + k), rd_v);
      chk(rd_v, 8'(8'h5a + k));
    end
    rd(4'ha, rd_v);
    chk(rd_v, 8'h00);
    $display("test registers done");
    // One enable at a time: each line, true and negated, both levels
    wr(lcig_pkg::OFF_POL, 8'h00);
    for (int k = 0; k < 4; k++) wr(4'(lcig_pkg::OFF_GLS0 + k), 8'h00);
    for (int gi = 0; gi < 4; gi++) begin
      for (int w = 0; w < 16; w++) begin
        wr(4'(lcig_pkg::OFF_GLS0 + gi), 8'(1 << (2 * w[3:2] + (w[1] ? 0 : 1))));
        @(posedge clk_in);
        source_in <= w[0] ? 64'h1 << sv[w[3:2]] : ~(64'h1 << sv[w[3:2]]);
        repeat (2) @(posedge clk_in);
        #1 chk({4'h0, gate_out}, (w[0] ^ w[1]) ? 8'(1 << gi) : 8'h00);
      end
      wr(4'(lcig_pkg::OFF_GLS0 + gi), 8'h00);
    end
    $display("test gating done");
    // No enables: gates show their polarity bits; combinational functions
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 32; p++) begin
        wr(lcig_pkg::OFF_POL, {p[4], 3'h0, p[3:0]});
        wr(lcig_pkg::OFF_CTRL, {5'h10, 3'(m)});
        repeat (2) @(posedge clk_in);
        #1 chk({4'h0, gate_out}, {4'h0, p[3:0]});
        g = p[3:0];
        e = (m == 0) ? (g[0] & g[1]) | (g[2] & g[3]) :
            (m == 1) ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g;
        chk({7'h0, cell_result_out}, {7'h0, e ^ p[4]});
        rd(lcig_pkg::OFF_CTRL, rd_v);
        chk(rd_v, {2'b10, e ^ p[4], 2'h0, 3'(m)});
      end
    end
    // Every function code with the cell off and output inverted
    for (int m = 0; m < 8; m++) begin
      wr(lcig_pkg::OFF_CTRL, {5'h0f, 3'(m)});
      rd(lcig_pkg::OFF_CTRL, rd_v);
      chk(rd_v, {5'h00, 3'(m)});
      chk({7'h0, cell_result_out}, 8'h00);
    end
    // Set-reset latch: gate 0 sets, gate 2 clears, state held in between
    for (int s = 0; s < 4; s++) begin
      wr(lcig_pkg::OFF_POL, sl_pol[s]);
      if (s == 0) wr(lcig_pkg::OFF_CTRL, 8'h83);
      repeat (3) @(posedge clk_in);
      #1 chk({7'h0, cell_result_out}, {7'h0, sl_exp[s]});
    end
    $display("test function done");
    // Reset in mid-run keeps selection and gate polarity
    wr(lcig_pkg::OFF_POL, 8'h85);
    wr(lcig_pkg::OFF_CTRL, 8'h82);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(lcig_pkg::OFF_POL, rd_v);
    chk(rd_v, 8'h05);
    rd(lcig_pkg::OFF_CTRL, rd_v);
    chk(rd_v, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rd(4'(lcig_pkg::OFF_SEL0 + k), rd_v);
      chk(rd_v, {2'b00, sv[k]});
    end
    $display("test reset done");
    results();
  end
endmodule

`default_nettype wire
